// ---- hw/rls_slot_scheduler.sv ----
// Return-link slot scheduler: slot timing, burst time plan intake, burst gating
//
// Function
// - Logon burst reports fixed or dynamic capability
// - Fixed burst parameters change only at superframe
// - Fixed mode mixes sync and traffic bursts
// - Dynamic mode changes parameters burst to burst
// - Hop within guard, or declared one-slot gap
// - Retune settled within one second
// - Superframes contiguous, each labelled by count
// - Transmit only in assigned or contention slots
// - Allocation applies per superframe, never per frame
// - Probe slots granted on long periods
// - Frames numbered from zero, at most 31
// - Timeslots numbered from zero, at most 2047
// - Slot identified by area, count, frame, slot
// - Parse own-area plan: count and allocations
// - Ready within 90 ms of plan
// - Continuous carrier ready within two seconds
// - No traffic before fine synchronisation
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
module rls_slot_scheduler #(
    parameter int TUNE_CYC = rls_pkg::TUNE_CYC_DFLT,
    parameter int PLAN_CYC = rls_pkg::PLAN_CYC_DFLT,
    parameter int CONT_CYC = rls_pkg::CONT_CYC_DFLT
) (
    input  wire logic                         clk_sys,
    input  wire logic                         arst_n,
    input  wire logic [3:0]                   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    output logic [31:0]                       avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic                         slot_strobe,
    input  wire logic                         sync_fine,
    input  wire logic                         btp_valid,
    input  wire logic                         btp_last,
    input  wire logic [rls_pkg::AREA_W-1:0]   btp_area_id,
    input  wire logic [rls_pkg::SFC_W-1:0]    btp_sf_count,
    input  wire logic [5:0]                   btp_frame,
    input  wire logic [11:0]                  btp_slot,
    input  wire logic                         btp_contention,
    input  wire logic [rls_pkg::CAR_W-1:0]    btp_carrier,
    input  wire logic [rls_pkg::PAR_W-1:0]    btp_param,
    output logic                              tx_grant,
    output logic                              tx_traffic,
    output logic [rls_pkg::CAR_W-1:0]         tx_carrier,
    output logic [rls_pkg::PAR_W-1:0]         tx_param,
    output logic                              logon_dyn_capable,
    output logic                              logon_hop_gap,
    output logic [rls_pkg::SFC_W-1:0]         sf_count,
    output logic [rls_pkg::FRAME_W-1:0]       frame_num,
    output logic [rls_pkg::SLOT_W-1:0]        slot_num
);
    import rls_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                           wait_reg,     wait_next;
    logic [31:0]                    rdata_reg,    rdata_next;
    logic [31:0]                    ctrl_reg,     ctrl_next;
    logic [31:0]                    probe_reg,    probe_next;
    logic [SLOT_W-1:0]              geom_reg,     geom_next;
    logic [AREA_W-1:0]              area_reg,     area_next;
    logic [PAR_W-1:0]               param_reg,    param_next;
    logic [4:2]                     sticky_reg,   sticky_next;
    logic [CNT_W-1:0]               tune_reg,     tune_next;
    rls_plan_state_type             pl_reg,       pl_next;
    rls_entry_type [TBL_N-1:0]      shadow_reg,   shadow_next;
    rls_entry_type [TBL_N-1:0]      active_reg,   active_next;
    logic [IDX_W:0]                 sh_cnt_reg,   sh_cnt_next;
    logic [IDX_W:0]                 act_cnt_reg,  act_cnt_next;
    logic [SFC_W-1:0]               target_reg,   target_next;
    logic [CNT_W-1:0]               lat_reg,      lat_next;
    logic                           ready_reg,    ready_next;
    logic [FRAME_W-1:0]             frame_reg,    frame_next;
    logic [SLOT_W-1:0]              slot_reg,     slot_next;
    logic [SFC_W-1:0]               sfc_reg,      sfc_next;
    logic [PAR_W-1:0]               act_par_reg,  act_par_next;
    logic [7:0]                     probe_cnt_reg, probe_cnt_next;
    logic                           eval_reg,     eval_next;
    logic                           grant_reg,    grant_next;
    logic                           traffic_reg,  traffic_next;
    logic [CAR_W-1:0]               car_reg,      car_next;
    logic [PAR_W-1:0]               txpar_reg,    txpar_next;
    logic                           prev_tx_reg,  prev_tx_next;

    logic                           bad_set;
    logic                           lat_set;
    logic                           hop_set;
    logic                           sf_wrap;
    logic                           tune_busy;
    logic                           hop_conf;
    logic [FRAME_W-1:0]             last_frame;

    assign last_frame = ctrl_reg[CTRL_NFRM +: FRAME_W];
    assign tune_busy  = (tune_reg != '0);
    // Last slot of last frame closes the superframe
    assign sf_wrap    = slot_strobe && (slot_reg == geom_reg) && (frame_reg == last_frame);

    // Search the active plan for the current frame and slot
    function automatic logic [IDX_W:0] tbl_find(input rls_entry_type [TBL_N-1:0] t,
                                               input logic [IDX_W:0] n,
                                               input logic [FRAME_W-1:0] f,
                                               input logic [SLOT_W-1:0] s);
        logic [IDX_W:0] r;
        r = 5'h00;
        for (int i = TBL_N - 1; i >= 0; i--) begin
            if ((i < int'(n)) && (t[i].frame == f) && (t[i].slot == s)) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction : tbl_find

    // ------------------------------------------------------------------
    // Register slave: one wait state on every access
    // ------------------------------------------------------------------
    always_comb begin
        wait_next   = 1'b1;
        rdata_next  = rdata_reg;
        ctrl_next   = ctrl_reg;
        probe_next  = probe_reg;
        geom_next   = geom_reg;
        area_next   = area_reg;
        param_next  = param_reg;
        tune_next   = tune_busy ? tune_reg - 1'b1 : tune_reg;
        sticky_next = sticky_reg;
        if ((avs_read || avs_write) && wait_reg) begin
            wait_next = 1'b0;
            unique case (avs_address)
                REG_CTRL:   rdata_next = ctrl_reg;
                REG_GEOM:   rdata_next = {21'h000000, geom_reg};
                REG_AREA:   rdata_next = {24'h000000, area_reg};
                REG_PARAM:  rdata_next = {28'h0000000, param_reg};
                REG_PROBE:  rdata_next = probe_reg;
                REG_STATUS: rdata_next = {sfc_reg, 3'h0, act_cnt_reg, 3'h0, sticky_reg, tune_busy, ready_reg};
                REG_POS:    rdata_next = {5'h00, slot_reg, 11'h000, frame_reg};
                default:    rdata_next = 32'h0000_0000;
            endcase
        end
        // Write lands at the edge where waitrequest is seen low
        if (avs_write && !wait_reg) begin
            unique case (avs_address)
                REG_CTRL:   ctrl_next  = avs_writedata & CTRL_MASK;
                REG_GEOM:   geom_next  = avs_writedata[SLOT_W-1:0];
                REG_AREA:   area_next  = avs_writedata[AREA_W-1:0];
                REG_PARAM:  param_next = avs_writedata[PAR_W-1:0];
                REG_TUNE:   tune_next  = CNT_W'(TUNE_CYC);
                REG_PROBE:  probe_next = avs_writedata & PROBE_MASK;
                REG_STATUS: sticky_next = sticky_reg & ~avs_writedata[4:2];
                default:    ;
            endcase
        end
        // A new event beats a clear in the same cycle
        sticky_next = sticky_next | {hop_set, lat_set, bad_set};
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wait_reg   <= 1'b1;
            rdata_reg  <= 32'h0000_0000;
            ctrl_reg   <= CTRL_RST;
            probe_reg  <= PROBE_RST;
            geom_reg   <= GEOM_RST;
            area_reg   <= AREA_RST;
            param_reg  <= PARAM_RST;
            tune_reg   <= '0;
            sticky_reg <= 3'h0;
        end else begin
            wait_reg   <= wait_next;
            rdata_reg  <= rdata_next;
            ctrl_reg   <= ctrl_next;
            probe_reg  <= probe_next;
            geom_reg   <= geom_next;
            area_reg   <= area_next;
            param_reg  <= param_next;
            tune_reg   <= tune_next;
            sticky_reg <= sticky_next;
        end
    end

    // ------------------------------------------------------------------
    // Burst time plan intake into the shadow table
    // ------------------------------------------------------------------
    always_comb begin
        logic [IDX_W:0] base;
        base         = (pl_reg == PL_LOAD) ? sh_cnt_reg : 5'h00;
        pl_next      = pl_reg;
        shadow_next  = shadow_reg;
        sh_cnt_next  = sh_cnt_reg;
        target_next  = target_reg;
        lat_next     = lat_reg;
        ready_next   = ready_reg;
        active_next  = active_reg;
        act_cnt_next = act_cnt_reg;
        bad_set      = 1'b0;
        lat_set      = 1'b0;
        if (pl_reg == PL_LOAD) begin
            lat_next = lat_reg + 1'b1;
        end
        if (btp_valid) begin
            if (pl_reg != PL_LOAD) begin
                sh_cnt_next = 5'h00;
                lat_next    = '0;
                ready_next  = 1'b0;
            end
            // Foreign areas are skipped; own entries checked for range
            if (btp_area_id == area_reg) begin
                if ((btp_frame > 6'(MAX_FRAME)) || (btp_slot > 12'(MAX_SLOT))) begin
                    bad_set = 1'b1;
                end else if (base < 5'(TBL_N)) begin
                    shadow_next[base[IDX_W-1:0]] = '{btp_contention, btp_frame[FRAME_W-1:0],
                        btp_slot[SLOT_W-1:0], btp_carrier, btp_param};
                    sh_cnt_next = base + 1'b1;
                    target_next = btp_sf_count;
                end
            end
            pl_next = btp_last ? PL_PEND : PL_LOAD;
            if (btp_last) begin
                ready_next = 1'b1;
            end
        end else if ((pl_reg == PL_LOAD) &&
                     (lat_reg >= CNT_W'(ctrl_reg[CTRL_CONT] ? CONT_CYC : PLAN_CYC))) begin
            // Message too slow to meet the readiness budget: drop it
            lat_set = 1'b1;
            pl_next = PL_IDLE;
        end
        // Plans swap in only at the superframe they name
        if (sf_wrap && (pl_reg == PL_PEND) && (target_reg == sfc_reg + 1'b1)) begin
            active_next  = shadow_reg;
            act_cnt_next = sh_cnt_reg;
            pl_next      = btp_valid ? pl_next : PL_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pl_reg      <= PL_IDLE;
            shadow_reg  <= '0;
            active_reg  <= '0;
            sh_cnt_reg  <= 5'h00;
            act_cnt_reg <= 5'h00;
            target_reg  <= '0;
            lat_reg     <= '0;
            ready_reg   <= 1'b0;
        end else begin
            pl_reg      <= pl_next;
            shadow_reg  <= shadow_next;
            active_reg  <= active_next;
            sh_cnt_reg  <= sh_cnt_next;
            act_cnt_reg <= act_cnt_next;
            target_reg  <= target_next;
            lat_reg     <= lat_next;
            ready_reg   <= ready_next;
        end
    end

    // ------------------------------------------------------------------
    // Slot timing and burst gating
    // ------------------------------------------------------------------
    always_comb begin
        logic [IDX_W:0] hit;
        logic           probe_hit;
        logic           cand;
        hit            = tbl_find(active_reg, act_cnt_reg, frame_reg, slot_reg);
        probe_hit      = probe_reg[PROBE_EN] && (probe_cnt_reg == 8'h00) &&
                         (probe_reg[PROBE_FRM +: FRAME_W] == frame_reg) &&
                         (probe_reg[PROBE_SLOT +: SLOT_W] == slot_reg);
        // Traffic needs fine sync; probe slots do not
        cand = ctrl_reg[CTRL_EN] && !tune_busy && ((hit[IDX_W] && sync_fine) || probe_hit);
        frame_next     = frame_reg;
        slot_next      = slot_reg;
        sfc_next       = sfc_reg;
        act_par_next   = act_par_reg;
        probe_cnt_next = probe_cnt_reg;
        eval_next      = slot_strobe;
        if (slot_strobe) begin
            slot_next = (slot_reg == geom_reg) ? 11'h000 : slot_reg + 1'b1;
            if (slot_reg == geom_reg) begin
                frame_next = (frame_reg == last_frame) ? 5'h00 : frame_reg + 1'b1;
            end
        end
        if (sf_wrap) begin
            sfc_next       = sfc_reg + 1'b1;
            act_par_next   = param_reg;
            probe_cnt_next = (probe_cnt_reg == 8'h00) ? probe_reg[PROBE_PER +: 8] : probe_cnt_reg - 1'b1;
        end
        car_next = hit[IDX_W] ? active_reg[hit[IDX_W-1:0]].carrier : probe_reg[PROBE_CAR +: CAR_W];
        // Declared gap: no back-to-back bursts on different carriers
        hop_conf = ctrl_reg[CTRL_HOPGAP] && prev_tx_reg && cand && (car_next != car_reg);
        hop_set  = eval_reg && hop_conf;
        grant_next   = grant_reg;
        traffic_next = traffic_reg;
        txpar_next   = txpar_reg;
        prev_tx_next = prev_tx_reg;
        if (eval_reg) begin
            grant_next   = cand && !hop_conf;
            traffic_next = cand && !hop_conf && hit[IDX_W] && sync_fine;
            prev_tx_next = cand && !hop_conf;
            // Dynamic mode takes each entry's own rate and coding
            txpar_next   = (ctrl_reg[CTRL_DYN] && hit[IDX_W]) ?
                           active_reg[hit[IDX_W-1:0]].param : act_par_reg;
        end else begin
            car_next = car_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            frame_reg     <= 5'h00;
            slot_reg      <= 11'h000;
            sfc_reg       <= 16'h0000;
            act_par_reg   <= PARAM_RST;
            probe_cnt_reg <= 8'h00;
            eval_reg      <= 1'b0;
            grant_reg     <= 1'b0;
            traffic_reg   <= 1'b0;
            car_reg       <= 3'h0;
            txpar_reg     <= 4'h0;
            prev_tx_reg   <= 1'b0;
        end else begin
            frame_reg     <= frame_next;
            slot_reg      <= slot_next;
            sfc_reg       <= sfc_next;
            act_par_reg   <= act_par_next;
            probe_cnt_reg <= probe_cnt_next;
            eval_reg      <= eval_next;
            grant_reg     <= grant_next;
            traffic_reg   <= traffic_next;
            car_reg       <= car_next;
            txpar_reg     <= txpar_next;
            prev_tx_reg   <= prev_tx_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign avs_readdata      = rdata_reg;
    assign avs_waitrequest   = wait_reg;
    assign tx_grant          = grant_reg;
    assign tx_traffic        = traffic_reg;
    assign tx_carrier        = car_reg;
    assign tx_param          = txpar_reg;
    assign logon_dyn_capable = ctrl_reg[CTRL_DYNCAP];
    assign logon_hop_gap     = ctrl_reg[CTRL_HOPGAP];
    assign sf_count          = sfc_reg;
    assign frame_num         = frame_reg;
    assign slot_num          = slot_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_plan_end;
        btp_valid && btp_last ##1 ready_reg;
    endsequence

    a_grant_on_eval:    assert property ($rose(grant_reg) |-> $past(eval_reg))
        else $error("grant rose outside a slot evaluation");
    a_traffic_sync:     assert property (eval_reg && !sync_fine |=> !traffic_reg)
        else $error("traffic granted without fine sync");
    a_sf_wrap_count:    assert property (sf_wrap |=> frame_reg == 5'h00 && slot_reg == 11'h000
                                         && sfc_reg == $past(sfc_reg) + 1'b1)
        else $error("superframe wrap did not restart numbering");
    a_bad_entry_flag:   assert property (btp_valid && btp_area_id == area_reg &&
                                         btp_frame > 6'd31 |=> sticky_reg[ST_BAD])
        else $error("out-of-range frame not flagged");
    a_plan_ready:       assert property (btp_valid && btp_last |-> s_plan_end)
        else $error("plan not ready one cycle after message end");
    a_tune_blocks:      assert property (eval_reg && tune_busy |=> !grant_reg)
        else $error("burst granted while retuning");
    a_param_boundary:   assert property ($changed(act_par_reg) |-> $past(sf_wrap))
        else $error("fixed parameters changed inside a superframe");
    a_plan_boundary:    assert property ($changed(active_reg) |-> $past(sf_wrap))
        else $error("plan applied off a superframe boundary");
    a_hop_gap:          assert property (eval_reg && hop_conf |=> !grant_reg && sticky_reg[ST_HOP])
        else $error("declared hop gap not respected");
endmodule : rls_slot_scheduler

// ---- hw/rls_pkg.sv ----
// Constants, register map and types of the return-link slot scheduler
package rls_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ         = 20_000_000;
    localparam int TUNE_SETTLE_MS = 1000;
    localparam int PLAN_LAT_MS    = 90;
    localparam int CONT_LAT_MS    = 2000;
    // Longest times, so the counts round down
    localparam int TUNE_CYC_DFLT  = (CLK_HZ / 1000) * TUNE_SETTLE_MS;
    localparam int PLAN_CYC_DFLT  = (CLK_HZ / 1000) * PLAN_LAT_MS;
    localparam int CONT_CYC_DFLT  = (CLK_HZ / 1000) * CONT_LAT_MS;
    localparam int CNT_W          = 26;

    // ------------------------------------------------------------------
    // Numbering limits and widths
    // ------------------------------------------------------------------
    localparam int MAX_FRAME = 31;
    localparam int MAX_SLOT  = 2047;
    localparam int FRAME_W   = 5;
    localparam int SLOT_W    = 11;
    localparam int SFC_W     = 16;
    localparam int AREA_W    = 8;
    localparam int CAR_W     = 3;
    localparam int PAR_W     = 4;
    localparam int TBL_N     = 16;
    localparam int IDX_W     = 4;

    // ------------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_GEOM   = 4'h1;
    localparam logic [3:0] REG_AREA   = 4'h2;
    localparam logic [3:0] REG_PARAM  = 4'h3;
    localparam logic [3:0] REG_TUNE   = 4'h4;
    localparam logic [3:0] REG_PROBE  = 4'h5;
    localparam logic [3:0] REG_STATUS = 4'h6;
    localparam logic [3:0] REG_POS    = 4'h7;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_EN      = 0;
    localparam int CTRL_DYN     = 1;
    localparam int CTRL_CONT    = 2;
    localparam int CTRL_HOPGAP  = 3;
    localparam int CTRL_DYNCAP  = 4;
    localparam int CTRL_NFRM    = 8;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_1F1F;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam int PROBE_FRM    = 0;
    localparam int PROBE_SLOT   = 5;
    localparam int PROBE_PER    = 16;
    localparam int PROBE_CAR    = 24;
    localparam int PROBE_EN     = 31;
    localparam logic [31:0] PROBE_MASK = 32'h87FF_FFFF;
    localparam logic [31:0] PROBE_RST  = 32'h0000_0000;
    localparam logic [SLOT_W-1:0] GEOM_RST  = 11'h000;
    localparam logic [AREA_W-1:0] AREA_RST  = 8'h00;
    localparam logic [PAR_W-1:0]  PARAM_RST = 4'h0;
    localparam int ST_BAD = 2;
    localparam int ST_LAT = 3;
    localparam int ST_HOP = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic               cont;
        logic [FRAME_W-1:0] frame;
        logic [SLOT_W-1:0]  slot;
        logic [CAR_W-1:0]   carrier;
        logic [PAR_W-1:0]   param;
    } rls_entry_type;

    typedef enum logic [1:0] {
        PL_IDLE = 2'b00,
        PL_LOAD = 2'b01,
        PL_PEND = 2'b10
    } rls_plan_state_type;
endpackage : rls_pkg

// ---- verification/rls_ncc_model.sv ----
// Network controller model: issues burst time plan entries
`timescale 1ns/1ns
module rls_ncc_model (
    input  wire logic  clk_sys,
    output logic       btp_valid,
    output logic       btp_last,
    output logic [7:0] btp_area_id,
    output logic [15:0] btp_sf_count,
    output logic [5:0] btp_frame,
    output logic [11:0] btp_slot,
    output logic       btp_contention,
    output logic [2:0] btp_carrier,
    output logic [3:0] btp_param
);
    // Quiet at start
    initial begin
        {btp_valid, btp_last, btp_area_id, btp_sf_count, btp_frame} = '0;
        {btp_slot, btp_contention, btp_carrier, btp_param} = '0;
    end
    // One entry per edge; valid stays up inside a message
    task automatic send(input logic [7:0] a, input logic [15:0] s, input logic [5:0] f, input logic l);
        btp_valid <= 1'b1;
        btp_last <= l;
        {btp_area_id, btp_sf_count, btp_frame} <= {a, s, f};
        {btp_slot, btp_contention, btp_carrier, btp_param} <= {12'h000, 1'b0, 3'h2, 4'h0};
        @(posedge clk_sys);
        if (l) begin
            btp_valid <= 1'b0;
            btp_last <= 1'b0;
            {btp_area_id, btp_sf_count, btp_frame} <= ~{a, s, f}; // Stale fields must not match
        end
    endtask : send
endmodule : rls_ncc_model

// ---- verification/rls_slot_scheduler_tb.sv ----
// Testbench of the return-link slot scheduler
`timescale 1ns/1ns
module rls_slot_scheduler_tb;
    import rls_pkg::*;
    logic clk_sys, arst_n, avs_read, avs_write, slot_strobe, sync_fine, avs_waitrequest, tx_grant, tx_traffic;
    logic logon_dyn_capable, logon_hop_gap, btp_valid, btp_last, btp_contention;
    logic [3:0] avs_address, btp_param, tx_param;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] btp_area_id;
    logic [15:0] btp_sf_count, sf_count, t;
    logic [5:0] btp_frame;
    logic [11:0] btp_slot;
    logic [2:0] btp_carrier, tx_carrier;
    logic [4:0] frame_num;
    logic [10:0] slot_num;
    int bad_count = 0;
    int tests_run = 0;
    // Short counts keep the run brief
    rls_slot_scheduler #(.TUNE_CYC(20), .PLAN_CYC(30), .CONT_CYC(60)) i_rls_slot_scheduler (.clk_sys, .arst_n,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .slot_strobe,
        .sync_fine, .btp_valid, .btp_last, .btp_area_id, .btp_sf_count, .btp_frame, .btp_slot, .btp_contention,
        .btp_carrier, .btp_param, .tx_grant, .tx_traffic, .tx_carrier, .tx_param, .logon_dyn_capable,
        .logon_hop_gap, .sf_count, .frame_num, .slot_num);
    rls_ncc_model i_rls_ncc_model (.clk_sys, .btp_valid, .btp_last, .btp_area_id, .btp_sf_count, .btp_frame,
        .btp_slot, .btp_contention, .btp_carrier, .btp_param);
    task automatic close_out;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    // Avalon access; waits for waitrequest low under a bound
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        @(posedge clk_sys);
        if (n == 20) begin
            chk(1'b0, "bus hang");
            close_out;
        end
    endtask : bus
    // Strobe, then wait past the grant update
    task automatic step;
        slot_strobe <= 1'b1;
        @(posedge clk_sys);
        slot_strobe <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : step
    task automatic s_regs;
        bus(1'b1, REG_CTRL, 32'hFFFF_FFFF);
        bus(1'b0, REG_CTRL, 32'h0000_0000);
        chk(q === CTRL_MASK, "ctrl readback");
        chk(logon_dyn_capable === 1'b1 && logon_hop_gap === 1'b1, "logon fields");
        bus(1'b0, 4'h9, 32'h0000_0000);
        chk(q === 32'h0000_0000, "unmapped read");
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        bus(1'b1, REG_AREA, 32'h0000_0005);
        bus(1'b1, REG_PARAM, 32'h0000_0003);
    endtask : s_regs
    // Foreign and out-of-range entries ahead of one good entry
    task automatic s_plan;
        t = sf_count + 16'h0002;
        i_rls_ncc_model.send(8'h06, t, 6'h00, 1'b0);
        i_rls_ncc_model.send(8'h05, t, 6'h20, 1'b0);
        i_rls_ncc_model.send(8'h05, t, 6'h00, 1'b1);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        chk(q[2:0] === 3'b101, "plan status");
        step;
        chk(tx_grant === 1'b0 && sf_count === t - 16'h0001, "early grant");
        step;
        chk(tx_grant === 1'b1 && tx_traffic === 1'b1 && sf_count === t, "no grant");
        chk(tx_carrier === 3'h2 && tx_param === 4'h3, "burst fields");
        i_rls_ncc_model.send(8'h05, t + 16'h0001, 6'h00, 1'b1);
        sync_fine <= 1'b0;
        step;
        chk(tx_grant === 1'b0, "traffic without sync");
    endtask : s_plan
    // Retune blocks bursts until settled; dynamic mode takes the entry's parameters
    task automatic s_tune;
        sync_fine <= 1'b1;
        bus(1'b1, REG_TUNE, 32'h0000_0000);
        step;
        chk(tx_grant === 1'b0, "grant while retuning");
        repeat (5) step;
        chk(tx_grant === 1'b1 && tx_param === 4'h3, "no grant after retune");
        bus(1'b1, REG_CTRL, 32'h0000_0003);
        step;
        chk(tx_grant === 1'b1 && tx_param === 4'h0, "dynamic parameters");
    endtask : s_tune
    // Three slots, two frames: walk the numbering through one wrap
    task automatic s_geom;
        bus(1'b1, REG_GEOM, 32'h0000_0002);
        bus(1'b1, REG_CTRL, 32'h0000_0101);
        t = sf_count;
        repeat (4) step;
        chk(slot_num === 11'h001 && frame_num === 5'h01 && sf_count === t, "slot numbering");
        chk(tx_grant === 1'b0, "grant outside plan");
        repeat (2) step;
        chk(slot_num === 11'h000 && frame_num === 5'h00 && sf_count === t + 16'h0001, "superframe wrap");
    endtask : s_geom
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        {arst_n, avs_read, avs_write, slot_strobe, avs_address, avs_writedata} = '0;
        sync_fine = 1'b1;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        s_regs;
        s_plan;
        s_tune;
        s_geom;
        close_out;
    end
endmodule : rls_slot_scheduler_tb
